//--- src/shared_pin_io_ports.sv
// parallel ports of the tuning controller with shared alternate pins
// assumes synchronous pin inputs and a one-cycle strobed register port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pin_io_defines.svh"

module shared_pin_io_ports (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // register port
  input  wire pin_io_pkg::reg_addr_t regAddr,
  input  wire pin_io_pkg::reg_byte_t regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output pin_io_pkg::reg_byte_t      regRdata,
  // first port pins
  input  wire logic [7:0]            firstPortIn,
  output logic      [7:0]            firstPortOut,
  output logic      [7:0]            firstPortOe,
  // second port pins
  input  wire logic [7:0]            secondPortIn,
  output logic      [7:0]            secondPortOut,
  output logic      [7:0]            secondPortOe,
  // third port pins
  input  wire logic [7:0]            thirdPortIn,
  output logic      [7:0]            thirdPortOut,
  output logic      [7:0]            thirdPortOe,
  // fourth port pins
  input  wire logic [6:0]            fourthPortIn,
  output logic      [6:0]            fourthPortOut,
  output logic      [6:0]            fourthPortOe,
  // fifth port pins
  input  wire logic [7:0]            fifthPortIn,
  output logic      [7:0]            fifthPortOut,
  output logic      [7:0]            fifthPortOe,
  // sixth output port pins, bits 2 to 6
  output logic      [6:2]            sixthOutputPort,
  // seventh port pins
  input  wire logic [7:0]            seventhPortIn,
  output logic      [7:0]            seventhPortOut,
  output logic      [7:0]            seventhPortOe,
  // fourth port inputs toward timers, interrupts, comparator
  output logic                       timerBExtClock,
  output logic                       timerCExtClock,
  output logic                       extIrqA,
  output logic                       extIrqB,
  output logic                       comparatorInA,
  output logic                       comparatorInB,
  // serial channel A
  input  wire logic                  serialADataOut,
  input  wire logic                  serialAClock,
  input  wire logic                  serialAReady,
  output logic                       serialADataIn,
  // serial channel B
  input  wire logic                  serialBDataOut,
  input  wire logic                  serialBClock,
  input  wire logic                  serialBReady,
  output logic                       serialBDataIn,
  // pulse-width outputs
  input  wire logic [7:0]            pulseWidthOutsLow,
  input  wire logic                  pulseWidthOutEight,
  input  wire logic                  pulseWidthOutNine,
  // display colour outputs: red, green, blue, intensity, blanking
  input  wire logic [4:0]            displayColour
);

  // reset release through two flip-flops
  logic rstSync1_q;
  logic rstN_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_q <= 1'b0;
      rstN_q     <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstN_q     <= rstSync1_q;
    end
  end

  // write decode
  wire logic wrFirstData    = regWr & (regAddr == `FIRST_DATA_ADDR);
  wire logic wrFirstDir     = regWr & (regAddr == `FIRST_DIR_ADDR);
  wire logic wrSecondData   = regWr & (regAddr == `SECOND_DATA_ADDR);
  wire logic wrSecondDir    = regWr & (regAddr == `SECOND_DIR_ADDR);
  wire logic wrThirdData    = regWr & (regAddr == `THIRD_DATA_ADDR);
  wire logic wrThirdDir     = regWr & (regAddr == `THIRD_DIR_ADDR);
  wire logic wrFourthData   = regWr & (regAddr == `FOURTH_DATA_ADDR);
  wire logic wrFourthDir    = regWr & (regAddr == `FOURTH_DIR_ADDR);
  wire logic wrFifthData    = regWr & (regAddr == `FIFTH_DATA_ADDR);
  wire logic wrFifthDir     = regWr & (regAddr == `FIFTH_DIR_ADDR);
  wire logic wrSixthData    = regWr & (regAddr == `SIXTH_DATA_ADDR);
  wire logic wrSixthCtrl    = regWr & (regAddr == `SIXTH_CTRL_ADDR);
  wire logic wrSeventhData  = regWr & (regAddr == `SEVENTH_DATA_ADDR);
  wire logic wrSeventhDir   = regWr & (regAddr == `SEVENTH_DIR_ADDR);
  wire logic wrFifthFunc    = regWr & (regAddr == `FIFTH_FUNC_ADDR);
  wire logic wrSeventhFunc  = regWr & (regAddr == `SEVENTH_FUNC_ADDR);

  // function select and sixth port registers
  pin_io_pkg::reg_byte_t fifthFunc_q;
  pin_io_pkg::reg_byte_t seventhFunc_q;
  logic [6:2]            sixthData_q;
  logic [6:2]            sixthCtrl_q;

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      fifthFunc_q   <= `FUNC_RESET;
      seventhFunc_q <= `FUNC_RESET;
      sixthData_q   <= '0;
      sixthCtrl_q   <= '0;
    end else begin
      if (wrFifthFunc) fifthFunc_q <= regWdata;
      if (wrSeventhFunc) seventhFunc_q <= regWdata;
      if (wrSixthData) sixthData_q <= regWdata[6:2];
      if (wrSixthCtrl) sixthCtrl_q <= regWdata[6:2];
    end
  end

  wire logic serA = fifthFunc_q[`FUNC_SERIAL_A];
  wire logic serB = fifthFunc_q[`FUNC_SERIAL_B];
  wire logic pulse_width_out_eight = fifthFunc_q[`FUNC_PWM_EIGHT];
  wire logic pulse_width_out_nine = fifthFunc_q[`FUNC_PWM_NINE];

  // fifth port routing; a pulse-width output wins over serial B
  wire logic [7:0] fifthAltEn = {
    pulse_width_out_eight | serB, pulse_width_out_nine, serB, serB, serA, 1'b0, serA, serA};
  wire logic [7:0] fifthAltVal = {
    pulse_width_out_eight ? pulseWidthOutEight : serialBReady,
    pulseWidthOutNine,
    serialBClock, serialBDataOut,
    serialAReady, 1'b0, serialAClock, serialADataOut};
  wire logic [7:0] fifthForceIn = {
    1'b0, serB & ~pulse_width_out_nine, 3'b000, serA, 2'b00};

  // per-port read values and direction registers
  logic [7:0] firstRead;
  logic [7:0] firstDir;
  logic [7:0] secondRead;
  logic [7:0] secondDir;
  logic [7:0] thirdRead;
  logic [7:0] thirdDir;
  logic [6:0] fourthRead;
  logic [6:0] fourthDir;
  logic [7:0] fifthRead;
  logic [7:0] fifthDir;
  logic [7:0] seventhRead;
  logic [7:0] seventhDir;

  port_slice #(.WIDTH(8), .OD_MASK(`PUSH_PULL_MASK)) uFirst (
    .clk      (mclk),
    .rstN     (rstN_q),
    .wrData   (wrFirstData),
    .wrDir    (wrFirstDir),
    .wdata    (regWdata),
    .readVal  (firstRead),
    .dirVal   (firstDir),
    .altOutEn (8'h00),
    .altOut   (8'h00),
    .forceIn  (8'h00),
    .pinIn    (firstPortIn),
    .pinOut   (firstPortOut),
    .pinOe    (firstPortOe)
  );

  port_slice #(.WIDTH(8), .OD_MASK(`PUSH_PULL_MASK)) uSecond (
    .clk      (mclk),
    .rstN     (rstN_q),
    .wrData   (wrSecondData),
    .wrDir    (wrSecondDir),
    .wdata    (regWdata),
    .readVal  (secondRead),
    .dirVal   (secondDir),
    .altOutEn (8'h00),
    .altOut   (8'h00),
    .forceIn  (8'h00),
    .pinIn    (secondPortIn),
    .pinOut   (secondPortOut),
    .pinOe    (secondPortOe)
  );

  port_slice #(.WIDTH(8), .OD_MASK(`PUSH_PULL_MASK)) uThird (
    .clk      (mclk),
    .rstN     (rstN_q),
    .wrData   (wrThirdData),
    .wrDir    (wrThirdDir),
    .wdata    (regWdata),
    .readVal  (thirdRead),
    .dirVal   (thirdDir),
    .altOutEn (8'h00),
    .altOut   (8'h00),
    .forceIn  (8'h00),
    .pinIn    (thirdPortIn),
    .pinOut   (thirdPortOut),
    .pinOe    (thirdPortOe)
  );

  port_slice #(.WIDTH(7), .OD_MASK({1'b0, `FOURTH_OD_MASK})) uFourth (
    .clk      (mclk),
    .rstN     (rstN_q),
    .wrData   (wrFourthData),
    .wrDir    (wrFourthDir),
    .wdata    (regWdata[6:0]),
    .readVal  (fourthRead),
    .dirVal   (fourthDir),
    .altOutEn (7'h00),
    .altOut   (7'h00),
    .forceIn  (7'h00),
    .pinIn    (fourthPortIn),
    .pinOut   (fourthPortOut),
    .pinOe    (fourthPortOe)
  );

  port_slice #(.WIDTH(8), .OD_MASK(`PUSH_PULL_MASK)) uFifth (
    .clk      (mclk),
    .rstN     (rstN_q),
    .wrData   (wrFifthData),
    .wrDir    (wrFifthDir),
    .wdata    (regWdata),
    .readVal  (fifthRead),
    .dirVal   (fifthDir),
    .altOutEn (fifthAltEn),
    .altOut   (fifthAltVal),
    .forceIn  (fifthForceIn),
    .pinIn    (fifthPortIn),
    .pinOut   (fifthPortOut),
    .pinOe    (fifthPortOe)
  );

  port_slice #(.WIDTH(8), .OD_MASK(`SEVENTH_OD_MASK)) uSeventh (
    .clk      (mclk),
    .rstN     (rstN_q),
    .wrData   (wrSeventhData),
    .wrDir    (wrSeventhDir),
    .wdata    (regWdata),
    .readVal  (seventhRead),
    .dirVal   (seventhDir),
    .altOutEn (seventhFunc_q),
    .altOut   (pulseWidthOutsLow),
    .forceIn  (8'h00),
    .pinIn    (seventhPortIn),
    .pinOut   (seventhPortOut),
    .pinOe    (seventhPortOe)
  );

  // sixth port: display signals replace the latch per control bit
  wire logic [6:2] sixthOut_d =
    (sixthCtrl_q & displayColour) | (~sixthCtrl_q & sixthData_q);

  // pin levels registered toward the other blocks, plus the sixth port output and read data registers
  logic                  timerBExtClock_q;
  logic                  timerCExtClock_q;
  logic                  extIrqA_q;
  logic                  extIrqB_q;
  logic                  comparatorInA_q;
  logic                  comparatorInB_q;
  logic                  serialADataIn_q;
  logic                  serialBDataIn_q;
  logic [6:2]            sixthOut_q;
  pin_io_pkg::reg_byte_t regRdata_q;

  // read selection; unmapped addresses read zero
  wire pin_io_pkg::reg_byte_t readMux =
    (regAddr == `FIRST_DATA_ADDR)   ? firstRead :
    (regAddr == `FIRST_DIR_ADDR)    ? firstDir :
    (regAddr == `SECOND_DATA_ADDR)  ? secondRead :
    (regAddr == `SECOND_DIR_ADDR)   ? secondDir :
    (regAddr == `THIRD_DATA_ADDR)   ? thirdRead :
    (regAddr == `THIRD_DIR_ADDR)    ? thirdDir :
    (regAddr == `FOURTH_DATA_ADDR)  ? {1'b0, fourthRead} :
    (regAddr == `FOURTH_DIR_ADDR)   ? {1'b0, fourthDir} :
    (regAddr == `FIFTH_DATA_ADDR)   ? fifthRead :
    (regAddr == `FIFTH_DIR_ADDR)    ? fifthDir :
    (regAddr == `SIXTH_DATA_ADDR)   ? {1'b0, sixthData_q, 2'b00} :
    (regAddr == `SIXTH_CTRL_ADDR)   ? {1'b0, sixthCtrl_q, 2'b00} :
    (regAddr == `SEVENTH_DATA_ADDR) ? seventhRead :
    (regAddr == `SEVENTH_DIR_ADDR)  ? seventhDir :
    (regAddr == `FIFTH_FUNC_ADDR)   ? {4'h0, fifthFunc_q[3:0]} :
    (regAddr == `SEVENTH_FUNC_ADDR) ? seventhFunc_q :
    `UNMAPPED_READ;

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      timerBExtClock_q <= 1'b0;
      timerCExtClock_q <= 1'b0;
      extIrqA_q        <= 1'b0;
      extIrqB_q        <= 1'b0;
      comparatorInA_q  <= 1'b0;
      comparatorInB_q  <= 1'b0;
      serialADataIn_q  <= 1'b0;
      serialBDataIn_q  <= 1'b0;
      sixthOut_q       <= '0;
      regRdata_q       <= '0;
    end else begin
      timerBExtClock_q <= fourthPortIn[2];
      timerCExtClock_q <= fourthPortIn[3];
      extIrqA_q        <= fourthPortIn[4];
      extIrqB_q        <= fourthPortIn[6];
      comparatorInA_q  <= fourthPortIn[5];
      comparatorInB_q  <= fourthPortIn[6];
      serialADataIn_q  <= fifthPortIn[2];
      serialBDataIn_q  <= fifthPortIn[6];
      sixthOut_q       <= sixthOut_d;
      regRdata_q       <= regRd ? readMux : `UNMAPPED_READ;
    end
  end

  assign timerBExtClock  = timerBExtClock_q;
  assign timerCExtClock  = timerCExtClock_q;
  assign extIrqA         = extIrqA_q;
  assign extIrqB         = extIrqB_q;
  assign comparatorInA   = comparatorInA_q;
  assign comparatorInB   = comparatorInB_q;
  assign serialADataIn   = serialADataIn_q;
  assign serialBDataIn   = serialBDataIn_q;
  assign sixthOutputPort = sixthOut_q;
  assign regRdata        = regRdata_q;

endmodule

//--- src/pin_io_defines.svh
// register offsets, field positions and reset values of the port block
// assumes an 8-bit register address space and 8-bit register data
`ifndef PIN_IO_DEFINES_SVH
`define PIN_IO_DEFINES_SVH

`define FIRST_DATA_ADDR    8'hC0
`define FIRST_DIR_ADDR     8'hC1
`define SECOND_DATA_ADDR   8'hC2
`define SECOND_DIR_ADDR    8'hC3
`define THIRD_DATA_ADDR    8'hC4
`define THIRD_DIR_ADDR     8'hC5
`define FOURTH_DATA_ADDR   8'hC6
`define FOURTH_DIR_ADDR    8'hC7
`define FIFTH_DATA_ADDR    8'hC8
`define FIFTH_DIR_ADDR     8'hC9
`define SIXTH_DATA_ADDR    8'hCA
`define SIXTH_CTRL_ADDR    8'hCB
`define SEVENTH_DATA_ADDR  8'hCC
`define SEVENTH_DIR_ADDR   8'hCD
`define FIFTH_FUNC_ADDR    8'hB0
`define SEVENTH_FUNC_ADDR  8'hB1

`define FUNC_SERIAL_A      0
`define FUNC_SERIAL_B      1
`define FUNC_PWM_EIGHT     2
`define FUNC_PWM_NINE      3

`define DATA_RESET         8'h00
`define DIR_RESET          8'h00
`define FUNC_RESET         8'h00
`define UNMAPPED_READ      8'h00

`define FOURTH_OD_MASK     7'h7C
`define SEVENTH_OD_MASK    8'hFF
`define PUSH_PULL_MASK     8'h00

`endif

//--- src/pin_io_pkg.sv
// types shared by the port block
// assumes nothing beyond SystemVerilog
package pin_io_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
endpackage

//--- src/port_slice.sv
// one bidirectional port: data latch, direction latch and pin drivers
// assumes writes come as one-cycle strobes from the register decoder
`timescale 1ns/1ps
`include "pin_io_defines.svh"

module port_slice #(
  parameter int         WIDTH   = 8,
  parameter logic [7:0] OD_MASK = `PUSH_PULL_MASK
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // register side
  input  wire logic             wrData,
  input  wire logic             wrDir,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] readVal,
  output logic      [WIDTH-1:0] dirVal,
  // alternate functions
  input  wire logic [WIDTH-1:0] altOutEn,
  input  wire logic [WIDTH-1:0] altOut,
  input  wire logic [WIDTH-1:0] forceIn,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut,
  output logic      [WIDTH-1:0] pinOe
);

  if (WIDTH < 1 || WIDTH > 8) begin : gWidthCheck
    $error("port_slice width must be 1 to 8");
  end

  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] pinOut_d;
  logic [WIDTH-1:0] pinOe_d;
  logic [WIDTH-1:0] pinOut_q;
  logic [WIDTH-1:0] pinOe_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      latch_q <= WIDTH'(`DATA_RESET);
      dir_q   <= WIDTH'(`DIR_RESET);
    end else begin
      if (wrData) latch_q <= wdata;
      if (wrDir) dir_q <= wdata;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : gBit
    wire logic effVal  = altOutEn[i] ? altOut[i] : latch_q[i];
    wire logic driving = altOutEn[i] | (dir_q[i] & ~forceIn[i]);
    if (OD_MASK[i]) begin : gOpenDrain
      // only pulls low, floats for a one
      assign pinOut_d[i] = 1'b0;
      assign pinOe_d[i]  = driving & ~effVal;
    end else begin : gPushPull
      assign pinOut_d[i] = effVal;
      assign pinOe_d[i]  = driving;
    end
    // inputs and alternate inputs read the pin
    assign readVal[i] = driving & ~altOutEn[i] ? latch_q[i] : pinIn[i];
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinOut_q <= '0;
      pinOe_q  <= '0;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q  <= pinOe_d;
    end
  end

  assign dirVal = dir_q;
  assign pinOut = pinOut_q;
  assign pinOe  = pinOe_q;

endmodule

//--- tb/shared_pin_io_ports_chk.sv
// concurrent checks on the port block, bound to its top module
// assumes one-cycle register strobes and registered copies of pin levels
`timescale 1ns/1ps
`include "pin_io_defines.svh"

module shared_pin_io_ports_chk (
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  rst_b,
  // register port
  input wire pin_io_pkg::reg_addr_t regAddr,
  input wire pin_io_pkg::reg_byte_t regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire pin_io_pkg::reg_byte_t regRdata,
  // pins
  input wire logic [7:0]            firstPortOe,
  input wire logic [7:0]            secondPortOe,
  input wire logic [6:0]            fourthPortIn,
  input wire logic [6:0]            fourthPortOut,
  input wire logic [7:0]            fifthPortIn,
  input wire logic [7:0]            seventhPortOut,
  // pin copies toward other blocks
  input wire logic                  timerBExtClock,
  input wire logic                  timerCExtClock,
  input wire logic                  extIrqA,
  input wire logic                  extIrqB,
  input wire logic                  comparatorInA,
  input wire logic                  comparatorInB,
  input wire logic                  serialADataIn,
  input wire logic                  serialBDataIn
);
  logic [1:0] upCnt_q;
  logic       live;

  // copies are only meaningful once the internal reset has let go
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) upCnt_q <= 2'h0;
    else if (upCnt_q != 2'h3) upCnt_q <= upCnt_q + 2'h1;
  end
  assign live = (upCnt_q == 2'h3);

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_dir_reset: assert property ($rose(rst_b) |->
    (firstPortOe == 8'h00 && secondPortOe == 8'h00) [*3])
    else $error("direction not cleared after reset");
  chk_first_dir_write: assert property (
    regWr && regAddr == `FIRST_DIR_ADDR ##1
    !(regWr && regAddr == `FIRST_DIR_ADDR) |->
    ##1 firstPortOe == $past(regWdata, 2))
    else $error("first port enables do not follow direction write");
  chk_fourth_od: assert property (fourthPortOut[6:2] == 5'h00)
    else $error("fourth port open-drain bit driven high");
  chk_seventh_od: assert property (seventhPortOut == 8'h00)
    else $error("seventh port open-drain bit driven high");
  chk_timer_clocks: assert property (live |->
    {timerCExtClock, timerBExtClock} == $past(fourthPortIn[3:2]))
    else $error("timer clock copies wrong");
  chk_irq_copies: assert property (live |->
    {extIrqB, extIrqA} == {$past(fourthPortIn[6]), $past(fourthPortIn[4])})
    else $error("interrupt copies wrong");
  chk_comparator_copies: assert property (live |->
    {comparatorInB, comparatorInA} == $past(fourthPortIn[6:5]))
    else $error("comparator copies wrong");
  chk_serial_data_in: assert property (live |->
    {serialBDataIn, serialADataIn} ==
    {$past(fifthPortIn[6]), $past(fifthPortIn[2])})
    else $error("serial data-in copies wrong");
  chk_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data present without a read");
  chk_unmapped_read: assert property (
    regRd && !(regAddr inside {[`FIRST_DATA_ADDR:`SEVENTH_DIR_ADDR],
    `FIFTH_FUNC_ADDR, `SEVENTH_FUNC_ADDR}) |=> regRdata == 8'h00)
    else $error("unmapped read returned data");

  cover property (regRd && regAddr == `FIRST_DIR_ADDR);
  cover property (regWr && regAddr == `SEVENTH_FUNC_ADDR);
  cover property (live && $rose(extIrqA));
endmodule

bind shared_pin_io_ports shared_pin_io_ports_chk shared_pin_io_ports_chk_i (
  .mclk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .firstPortOe, .secondPortOe, .fourthPortIn, .fourthPortOut, .fifthPortIn,
  .seventhPortOut, .timerBExtClock, .timerCExtClock, .extIrqA, .extIrqB,
  .comparatorInA, .comparatorInB, .serialADataIn, .serialBDataIn
);

//--- tb/board_pins.sv
// board side of one port: pull-up on every pin plus optional board drivers
// assumes pad enable high while the device drives the pin
`timescale 1ns/1ps

module board_pins #(
  parameter int W = 8
) (
  // pads from the device
  input  wire logic [W-1:0] padOut,
  input  wire logic [W-1:0] padOe,
  // board drivers
  input  wire logic [W-1:0] boardDrv,
  input  wire logic [W-1:0] boardEn,
  // resolved wire level
  output logic      [W-1:0] level
);
  // device drive wins, then a board driver, else the pull-up
  assign level = (padOe & padOut) | (~padOe & boardEn & boardDrv)
               | (~padOe & ~boardEn);
endmodule

//--- tb/shared_pin_io_ports_tb.sv
// self-checking bench for the port block
// assumes the strobed register port and registered pin paths
`timescale 1ns/1ps

module shared_pin_io_ports_tb;
  logic                  mclk;
  logic                  rst_b;
  pin_io_pkg::reg_addr_t regAddr;
  pin_io_pkg::reg_byte_t regWdata;
  logic                  regWr;
  logic                  regRd;
  pin_io_pkg::reg_byte_t regRdata;
  wire  [6:0][7:0]       pOut;
  wire  [6:0][7:0]       pOe;
  wire  [6:0][7:0]       lvl;
  logic [6:0][7:0]       drv;
  logic [6:0][7:0]       en;
  wire  [6:2]            sixth;
  wire  [5:0]            side;
  wire  [1:0]            serIn;
  logic [2:0]            serA;
  logic [2:0]            serB;
  logic [7:0]            pwmLow;
  logic                  pulse_width_out_eight;
  logic                  pulse_width_out_nine;
  logic [4:0]            colour;
  int                    failures;
  int                    total_checks;
  int                    cycles;

  shared_pin_io_ports shared_pin_io_ports_i (
    .mclk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .firstPortIn(lvl[0]), .firstPortOut(pOut[0]), .firstPortOe(pOe[0]),
    .secondPortIn(lvl[1]), .secondPortOut(pOut[1]), .secondPortOe(pOe[1]),
    .thirdPortIn(lvl[2]), .thirdPortOut(pOut[2]), .thirdPortOe(pOe[2]),
    .fourthPortIn(lvl[3][6:0]), .fourthPortOut(pOut[3][6:0]),
    .fourthPortOe(pOe[3][6:0]),
    .fifthPortIn(lvl[4]), .fifthPortOut(pOut[4]), .fifthPortOe(pOe[4]),
    .sixthOutputPort(sixth),
    .seventhPortIn(lvl[6]), .seventhPortOut(pOut[6]),
    .seventhPortOe(pOe[6]),
    .timerBExtClock(side[0]), .timerCExtClock(side[1]),
    .extIrqA(side[2]), .extIrqB(side[3]),
    .comparatorInA(side[4]), .comparatorInB(side[5]),
    .serialADataOut(serA[0]), .serialAClock(serA[1]),
    .serialAReady(serA[2]), .serialADataIn(serIn[0]),
    .serialBDataOut(serB[0]), .serialBClock(serB[1]),
    .serialBReady(serB[2]), .serialBDataIn(serIn[1]),
    .pulseWidthOutsLow(pwmLow), .pulseWidthOutEight(pulse_width_out_eight),
    .pulseWidthOutNine(pulse_width_out_nine), .displayColour(colour)
  );

  // pads with no pin behind them: sixth port slot, fourth port bit 7
  assign {pOut[5], pOe[5]} = 16'h0000;
  assign {pOut[3][7], pOe[3][7]} = 2'h0;

  for (genvar g = 0; g < 7; g++) begin : pins
    board_pins #(.W(8)) board_pins_i (
      .padOut(pOut[g]), .padOe(pOe[g]), .boardDrv(drv[g]),
      .boardEn(en[g]), .level(lvl[g])
    );
  end

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("MISMATCH timeout expected 3000 seen %0d", cycles);
      end_sim();
    end
  end

  task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    regRd <= 1'h0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regWr <= 1'h0;
    regRd <= 1'h1;
    @(posedge mclk);
    regRd <= 1'h0;
    #1 chk8($sformatf("read %h", a), exp, regRdata);
  endtask

  task automatic idle(int n);
    @(posedge mclk);
    regWr <= 1'h0;
    regRd <= 1'h0;
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic board(int p, logic [7:0] d, logic [7:0] e);
    @(posedge mclk);
    regWr <= 1'h0;
    regRd <= 1'h0;
    drv[p] <= d;
    en[p] <= e;
  endtask

  initial begin
    {regAddr, regWdata, regWr, regRd, serA, serB} = '0;
    {drv, en, pwmLow, pulse_width_out_eight, pulse_width_out_nine, colour} = '0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    rst_b = 1'h0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'h1;
    idle(3);
    wr(8'h55, 8'hFF);
    for (int i = 0; i < 14; i++)
      rd(8'hC0 + 8'(i), (i % 2) ? 8'h00 : (i == 6) ? 8'h7F :
         (i == 10) ? 8'h00 : 8'hFF);
    rd(8'h55, 8'h00);
    rd(8'hCE, 8'h00);
    rd(8'hB0, 8'h00);
    for (int p = 0; p < 7; p++)
      if (p != 5) chk8("enable", 8'h00, pOe[p] & 8'h7F);
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      wr(8'hC1 + 8'(2 * p), 8'hFF);
      wr(8'hC0 + 8'(2 * p), 8'hA5);
      idle(2);
      chk8("port out", 8'hA5, pOut[p]);
      chk8("port oe", 8'hFF, pOe[p]);
      wr(8'hC1 + 8'(2 * p), 8'h0F);
      board(p, 8'h30, 8'hF0);
      idle(2);
      chk8("port oe", 8'h0F, pOe[p]);
      rd(8'hC0 + 8'(2 * p), 8'h35);
    end
    $display("test direction done");
    wr(8'hC7, 8'h7F);
    wr(8'hC6, 8'h55);
    idle(2);
    chk8("fourth out", 8'h01, pOut[3] & 8'h7F);
    chk8("fourth oe", 8'h2B, pOe[3] & 8'h7F);
    rd(8'hC6, 8'h55);
    wr(8'hC7, 8'h00);
    board(3, 8'h54, 8'h7F);
    idle(3);
    chk8("copies", 8'h2D, {2'h0, side});
    rd(8'hC6, 8'h54);
    board(3, 8'h2B, 8'h7F);
    idle(3);
    chk8("copies", 8'h12, {2'h0, side});
    $display("test fourth done");
    @(posedge mclk);
    serA <= 3'h5;
    serB <= 3'h3;
    pulse_width_out_eight <= 1'h1;
    board(4, 8'h00, 8'h04);
    wr(8'hB0, 8'h01);
    idle(2);
    chk8("fifth out", 8'h09, pOut[4]);
    chk8("fifth oe", 8'h0B, pOe[4]);
    chk8("serial in", 8'h02, {6'h00, serIn});
    wr(8'hB0, 8'h02);
    idle(2);
    chk8("fifth out", 8'h30, pOut[4]);
    chk8("fifth oe", 8'hB0, pOe[4]);
    wr(8'hB0, 8'hFF);
    idle(2);
    chk8("fifth out", 8'hB9, pOut[4]);
    chk8("fifth oe", 8'hFB, pOe[4]);
    rd(8'hB0, 8'h0F);
    $display("test fifth done");
    @(posedge mclk);
    pwmLow <= 8'h3C;
    wr(8'hCD, 8'hFF);
    wr(8'hCC, 8'h0F);
    idle(2);
    chk8("seventh oe", 8'hF0, pOe[6]);
    wr(8'hB1, 8'hA5);
    idle(2);
    chk8("seventh oe", 8'hD1, pOe[6]);
    rd(8'hB1, 8'hA5);
    $display("test seventh done");
    @(posedge mclk);
    colour <= 5'h02;
    wr(8'hCA, 8'hFF);
    wr(8'hCB, 8'h0C);
    idle(2);
    chk8("sixth pins", 8'h78, {1'h0, sixth, 2'h0});
    rd(8'hCA, 8'h7C);
    rd(8'hCB, 8'h0C);
    $display("test sixth done");
    end_sim();
  end
endmodule
